// *** core/spimsp_port.sv ***
// serial peripheral port, master or slave, with an AXI4-Lite register slave
//
// Notes on behaviour
// - master: select pin as output is plain GPIO
// - select as input pulled low in master: drop to slave
// - master loss also sets the done flag
// - stay slave until software sets master again
// - slave active while select low; MISO per direction
// - slave select high: pins inputs, logic reset
// - select rising mid-byte aborts both directions
// - interrupt when flag, enable and global enable
// - port enable gates every serial operation
// - bit order: one means LSB first
// - control bit 4 selects master operation
// - clock polarity sets the idle clock level
// - clock phase with polarity gives four modes
// - master clock divider from double-speed and rate
// - rate bits ignored while slave
// - done flag on transfer end or master loss
// - done cleared by vector, or status-then-data access
// - write while busy sets collision flag
// - status bits 5..1 read zero
// - data write starts; read returns receive buffer
// - master clocks exactly one byte then stops
// - receive buffer holds until next full byte
`timescale 1ns/1ns
module spimsp_port (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // AXI4-Lite write channels
  input  wire logic [spimsp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [spimsp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // port direction settings and select pin output value
  input  wire spimsp_pkg::spimsp_pins_t   pin_dir,
  input  wire logic                       ss_gpio_value,
  // interrupt interface to the processor
  input  wire logic                       global_irq_en,
  input  wire logic                       irq_vector_taken,
  output logic                            port_irq,
  // serial pins
  input  wire spimsp_pkg::spimsp_pins_t   pins_i,
  output spimsp_pkg::spimsp_pins_t        pins_o,
  output spimsp_pkg::spimsp_pins_t        pins_oe
);

  spimsp_pkg::spimsp_ctrl_t  ctrl;
  spimsp_pkg::spimsp_state_t state;
  logic       dbl_speed;
  logic       done_flag;
  logic       write_collision_flag_flag;
  logic       clr_armed;
  logic [7:0] tx_byte;
  logic [7:0] rx_shift;
  logic [7:0] rx_buf;
  logic [4:0] edge_cnt;
  logic [6:0] div_cnt;
  logic [6:0] half_limit;
  logic       sck_prev;
  logic [7:0] rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: write address and data are taken together
  logic wr_go;
  logic rd_go;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic wr_mapped;
  logic rd_mapped;

  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_lane0      = wr_go & s_axi_wstrb[0];
  assign wr_ctrl       = wr_lane0 & (s_axi_awaddr == spimsp_pkg::ADDR_CONTROL);
  assign wr_stat       = wr_lane0 & (s_axi_awaddr == spimsp_pkg::ADDR_STATUS);
  assign wr_data       = wr_lane0 & (s_axi_awaddr == spimsp_pkg::ADDR_DATA);
  assign rd_stat       = rd_go & (s_axi_araddr == spimsp_pkg::ADDR_STATUS);
  assign rd_data       = rd_go & (s_axi_araddr == spimsp_pkg::ADDR_DATA);
  assign wr_mapped     = (s_axi_awaddr == spimsp_pkg::ADDR_CONTROL) |
                         (s_axi_awaddr == spimsp_pkg::ADDR_STATUS) |
                         (s_axi_awaddr == spimsp_pkg::ADDR_DATA);
  assign rd_mapped     = (s_axi_araddr == spimsp_pkg::ADDR_CONTROL) |
                         (s_axi_araddr == spimsp_pkg::ADDR_STATUS) |
                         (s_axi_araddr == spimsp_pkg::ADDR_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // mode and event terms
  logic busy;
  logic slave_act;
  logic master_loss;
  logic abort;
  logic tick;
  logic edge_now;
  logic sample_now;
  logic start_master;
  logic data_access;
  logic [7:0] status_word;

  assign busy        = (state != spimsp_pkg::ST_IDLE) | (edge_cnt != 5'h00);
  // slave runs only while enabled and selected
  assign slave_act   = ctrl.enable & ~ctrl.master & ~pins_i.ss;
  // select as input pulled low means another master wants the bus
  assign master_loss = ctrl.enable & ctrl.master & ~pin_dir.ss & ~pins_i.ss;
  // any of these ends a byte at once, partial data is dropped
  assign abort       = ~ctrl.enable | master_loss |
                       (~ctrl.master & pins_i.ss);
  assign tick        = (state == spimsp_pkg::ST_SHIFT) & (div_cnt == half_limit);
  // slave edges come from the sampled pin; rate bits play no part here
  assign edge_now    = ctrl.master ? tick
                                   : (slave_act & (pins_i.sck != sck_prev));
  assign sample_now  = edge_now & (edge_cnt[0] == ctrl.clock_phase);
  assign start_master = wr_data & ~busy & ctrl.enable & ctrl.master;
  assign data_access = wr_data | rd_data;
  assign status_word = {done_flag, write_collision_flag_flag, 5'h00, dbl_speed};

  ////////////////////////////////////////////////////////////////////////////
  // master divider selection, doubled rates when double-speed is set
  always_comb begin
    case ({dbl_speed, ctrl.rate})
      3'b000:  half_limit = spimsp_pkg::HALF_DIV4;
      3'b001:  half_limit = spimsp_pkg::HALF_DIV16;
      3'b010:  half_limit = spimsp_pkg::HALF_DIV64;
      3'b011:  half_limit = spimsp_pkg::HALF_DIV128;
      3'b100:  half_limit = spimsp_pkg::HALF_DIV2;
      3'b101:  half_limit = spimsp_pkg::HALF_DIV8;
      3'b110:  half_limit = spimsp_pkg::HALF_DIV32;
      3'b111:  half_limit = spimsp_pkg::HALF_DIV64;
      default: half_limit = spimsp_pkg::HALF_DIV4;
    endcase
  end

  // bit position of the current output and sample bits
  logic [2:0] out_idx;
  logic [2:0] smp_idx;
  logic [2:0] out_pos;
  logic [2:0] smp_pos;
  logic [4:0] edge_m1;
  logic       in_bit;

  assign edge_m1 = (edge_cnt == 5'h00) ? 5'h00 : (edge_cnt - 5'h01);
  // phase 1 moves data on leading edges, phase 0 on trailing ones
  assign out_idx = ctrl.clock_phase ? edge_m1[3:1] : edge_cnt[3:1];
  assign smp_idx = edge_cnt[3:1];
  assign out_pos = ctrl.lsb_first ? out_idx : (spimsp_pkg::LAST_BIT - out_idx);
  assign smp_pos = ctrl.lsb_first ? smp_idx : (spimsp_pkg::LAST_BIT - smp_idx);
  assign in_bit  = ctrl.master ? pins_i.miso : pins_i.mosi;

  ////////////////////////////////////////////////////////////////////////////
  // control register; select loss overrides a same-cycle write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= spimsp_pkg::CONTROL_RESET;
    end else if (master_loss) begin
      ctrl.master <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl <= s_axi_wdata[7:0];
    end
  end

  // double-speed is the only writable status bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dbl_speed <= 1'b0;
    end else if (wr_stat) begin
      dbl_speed <= s_axi_wdata[spimsp_pkg::ST_DBL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= spimsp_pkg::ST_IDLE;
    end else if (abort) begin
      state <= spimsp_pkg::ST_IDLE;
    end else begin
      case (state)
        spimsp_pkg::ST_IDLE: begin
          if (start_master) begin
            state <= spimsp_pkg::ST_SHIFT;
          end else if (edge_cnt == spimsp_pkg::EDGES_PER_BYTE) begin
            state <= spimsp_pkg::ST_FINISH;
          end
        end
        spimsp_pkg::ST_SHIFT: begin
          // clock stops after exactly one byte
          if (edge_cnt == spimsp_pkg::EDGES_PER_BYTE) begin
            state <= spimsp_pkg::ST_FINISH;
          end
        end
        spimsp_pkg::ST_FINISH: state <= spimsp_pkg::ST_IDLE;
        default: state <= spimsp_pkg::ST_IDLE;
      endcase
    end
  end

  // half-period divider, only runs while the master shifts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 7'h00;
    end else if (tick || state != spimsp_pkg::ST_SHIFT) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // edge counter and receive shifter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt <= 5'h00;
      rx_shift <= spimsp_pkg::DATA_RESET;
    end else if (abort || state == spimsp_pkg::ST_FINISH) begin
      edge_cnt <= 5'h00;
    end else if (edge_now && edge_cnt != spimsp_pkg::EDGES_PER_BYTE) begin
      edge_cnt <= edge_cnt + 5'h01;
      if (sample_now) begin
        rx_shift[smp_pos] <= in_bit;
      end
    end
  end

  // slave clock history, kept fresh so no false edge at selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pins_i.sck;
    end
  end

  // transmit byte is single-buffered: loads only while idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte <= spimsp_pkg::DATA_RESET;
    end else if (wr_data && !busy) begin
      tx_byte <= s_axi_wdata[7:0];
    end
  end

  // receive buffer, overwritten only by a complete byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf <= spimsp_pkg::DATA_RESET;
    end else if (state == spimsp_pkg::ST_FINISH) begin
      rx_buf <= rx_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; a hardware set wins over a clear in the same cycle
  logic set_done;
  logic clr_flags;

  assign set_done  = (state == spimsp_pkg::ST_FINISH) | master_loss;
  assign clr_flags = clr_armed & data_access;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_flag <= 1'b0;
    end else if (set_done) begin
      done_flag <= 1'b1;
    end else if (clr_flags || irq_vector_taken) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_collision_flag_flag <= 1'b0;
    end else if (wr_data && busy) begin
      write_collision_flag_flag <= 1'b1;
    end else if (clr_flags) begin
      write_collision_flag_flag <= 1'b0;
    end
  end

  // a status read that sees a flag arms the clear by the next data access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_armed <= 1'b0;
    end else if (rd_stat && (done_flag || write_collision_flag_flag)) begin
      clr_armed <= 1'b1;
    end else if (data_access) begin
      clr_armed <= 1'b0;
    end
  end

  // interrupt request, gated by port and global enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= done_flag & ctrl.irq_en & global_irq_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered so clock and data move together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_o  <= '0;
      pins_oe <= '0;
    end else begin
      pins_o.sck  <= ctrl.clock_polarity ^ edge_cnt[0];
      pins_o.mosi <= tx_byte[out_pos];
      pins_o.miso <= tx_byte[out_pos];
      pins_o.ss   <= ss_gpio_value;
      // master: SCK, MOSI and select follow the user directions
      pins_oe.sck  <= ctrl.enable & ctrl.master & pin_dir.sck & ~master_loss;
      pins_oe.mosi <= ctrl.enable & ctrl.master & pin_dir.mosi & ~master_loss;
      pins_oe.ss   <= ctrl.enable & ctrl.master & pin_dir.ss;
      // slave: only MISO may drive, and only while selected
      pins_oe.miso <= slave_act & pin_dir.miso;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spimsp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? spimsp_pkg::RESP_OKAY : spimsp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read response; data reads return the receive buffer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= spimsp_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      rd_addr      <= 8'h00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      rd_addr      <= s_axi_araddr;
      s_axi_rresp  <= rd_mapped ? spimsp_pkg::RESP_OKAY : spimsp_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        spimsp_pkg::ADDR_CONTROL: s_axi_rdata <= {24'h00_0000, ctrl};
        spimsp_pkg::ADDR_STATUS:  s_axi_rdata <= {24'h00_0000, status_word};
        spimsp_pkg::ADDR_DATA:    s_axi_rdata <= {24'h00_0000, rx_buf};
        default:                  s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence loss_seen;
    master_loss;
  endsequence

  sequence fell_to_slave;
    !ctrl.master && done_flag && state == spimsp_pkg::ST_IDLE;
  endsequence

  chk_master_loss_drop: assert property (loss_seen |=> fell_to_slave)
    else $error("select loss did not drop master mode");

  chk_irq_gate_on: assert property (
    done_flag && ctrl.irq_en && global_irq_en |=> port_irq)
    else $error("interrupt not raised for enabled flag");

  chk_disabled_quiet: assert property (
    !ctrl.enable |=> !pins_oe.sck && !pins_oe.mosi && !pins_oe.miso && !pins_oe.ss)
    else $error("pin driven while port disabled");

  chk_sck_idle_level: assert property (
    ctrl.master && state == spimsp_pkg::ST_IDLE && edge_cnt == 5'h00
    |=> pins_o.sck == $past(ctrl.clock_polarity))
    else $error("idle clock level differs from polarity");

  chk_slave_abort_now: assert property (
    !ctrl.master && $rose(pins_i.ss) |=> edge_cnt == 5'h00 && state == spimsp_pkg::ST_IDLE)
    else $error("slave byte not aborted on select release");

  chk_status_reserved: assert property (
    s_axi_rvalid && rd_addr == spimsp_pkg::ADDR_STATUS |-> s_axi_rdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");

  chk_write_collision_flag_on_busy: assert property (
    wr_data && busy |=> write_collision_flag_flag && $stable(tx_byte))
    else $error("busy data write not flagged as collision");

  // the count still reads full during the finish cycle, so that cycle is left out
  sequence byte_done;
    edge_cnt == spimsp_pkg::EDGES_PER_BYTE && !abort && state != spimsp_pkg::ST_FINISH;
  endsequence

  chk_one_byte_stop: assert property (
    byte_done |=> state == spimsp_pkg::ST_FINISH ##1 done_flag && edge_cnt == 5'h00)
    else $error("byte end did not stop and flag");

  chk_rx_buf_hold: assert property (
    state != spimsp_pkg::ST_FINISH |=> $stable(rx_buf))
    else $error("receive buffer changed before a full byte");

  chk_master_start_run: assert property (
    start_master && !abort |=> state == spimsp_pkg::ST_SHIFT ##[1:70] edge_cnt != 5'h00)
    else $error("data write did not start the master clock");

endmodule

// *** core/spimsp_pkg.sv ***
// shared constants, register map and types of the serial port block
package spimsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map: printed index, byte address is four times the index
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] IDX_CONTROL  = 8'h0D;
  localparam logic [7:0] IDX_STATUS   = 8'h0E;
  localparam logic [7:0] IDX_DATA     = 8'h0F;
  localparam logic [7:0] ADDR_CONTROL = {IDX_CONTROL[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS  = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] ADDR_DATA    = {IDX_DATA[5:0], 2'b00};

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  // status field positions
  localparam int ST_DONE_BIT = 7;
  localparam int ST_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int ST_DBL_BIT  = 0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // serial framing: two clock edges per bit
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  // half-period counts minus one, for divide by 2 .. 128
  localparam logic [6:0] HALF_DIV2   = 7'h00;
  localparam logic [6:0] HALF_DIV4   = 7'h01;
  localparam logic [6:0] HALF_DIV8   = 7'h03;
  localparam logic [6:0] HALF_DIV16  = 7'h07;
  localparam logic [6:0] HALF_DIV32  = 7'h0F;
  localparam logic [6:0] HALF_DIV64  = 7'h1F;
  localparam logic [6:0] HALF_DIV128 = 7'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // control register layout, bit 7 first
  typedef struct packed {
    logic       irq_en;
    logic       enable;
    logic       lsb_first;
    logic       master;
    logic       clock_polarity;
    logic       clock_phase;
    logic [1:0] rate;
  } spimsp_ctrl_t;

  // one bit per serial pin
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spimsp_pins_t;

  // transfer sequencer, gray along idle -> shift -> finish
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_FINISH = 2'b11
  } spimsp_state_t;

endpackage

// *** testbench/spimsp_peer.sv ***
// far-side model: a serial slave that swaps one byte with the port
`timescale 1ns/1ns
module spimsp_peer (
  // clock
  input  wire logic       clk,
  // serial link
  input  wire logic       sel_b,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // mode and data, mode bit 2 lsb first, bit 1 polarity, bit 0 phase
  input  wire logic [2:0] mode,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx,
  output logic [7:0]      per
);
  logic       sck_q  = 1'b0;
  logic       idle_q = 1'b0;
  logic [7:0] cnt    = 8'h00;
  logic [2:0] k      = 3'h0;
  logic       lead;
  logic       samp;
  ////////////////////////////////////////
  // edge decode on the synchronous pin level
  assign lead = (sck != sck_q) && (sck != mode[1]);
  assign samp = (sck != sck_q) && (lead ^ mode[0]);
  // a released line toggles so a stale bit never looks valid
  assign miso = sel_b ? idle_q : tx[mode[2] ? k : 3'h7 - k];
  // bit index moves on the sampling edge, so the next bit follows it
  always_ff @(posedge clk) begin
    sck_q  <= sck;
    idle_q <= ~idle_q;
    cnt    <= lead ? 8'h01 : cnt + 8'h01;
    if (lead) begin
      per <= cnt;
    end
    if (sel_b) begin
      k <= 3'h0;
    end else if (samp) begin
      k  <= k + 3'h1;
      rx <= mode[2] ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench of the serial port: register tasks and link scenarios
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam logic [7:0] A_CTL = spimsp_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_ST  = spimsp_pkg::ADDR_STATUS;
  localparam logic [7:0] A_DAT = spimsp_pkg::ADDR_DATA;
  logic        clk = 1'b0, rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rd_q, ptx = 8'h00, prx, per;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, awready, wready, bvalid, arready, rvalid, port_irq;
  logic [1:0]  bresp, rresp, resp;
  logic        gie = 1'b0, vec = 1'b0, ss_ext = 1'b1, p_miso;
  logic [2:0]  mode = 3'h0;
  logic [7:0]  divs [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
  int          n_mismatch = 0, comparisons = 0, cyc = 0;
  spimsp_pkg::spimsp_pins_t pin_dir = 4'hD, pins_o, pins_oe, pins_w;
  ////////////////////////////////////////
  // nobody else drives sck and mosi: pulled low when released
  assign pins_w = {pins_oe.sck & pins_o.sck, pins_oe.mosi & pins_o.mosi,
                   pins_oe.miso ? pins_o.miso : p_miso, pins_oe.ss ? pins_o.ss : ss_ext};
  spimsp_port spimsp_port_i (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_dir(pin_dir), .ss_gpio_value(1'b0), .global_irq_en(gie),
    .irq_vector_taken(vec), .port_irq(port_irq),
    .pins_i(pins_w), .pins_o(pins_o), .pins_oe(pins_oe));
  spimsp_peer spimsp_peer_i (.clk(clk), .sel_b(pins_w.ss), .sck(pins_w.sck),
    .mosi(pins_w.mosi), .miso(p_miso), .mode(mode), .tx(ptx), .rx(prx), .per(per));
  ////////////////////////////////////////
  // clock and hang guard, well above the few thousand cycles needed
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // address and data offered together, each held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd_q = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(n, e, rdata)
  endtask
  // status polling is the only wait: no cycle count is assumed
  task automatic xfer(input logic [7:0] d);
    wr(A_DAT, d);
    do rd(A_ST); while (rd_q[7] !== 1'b1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, reserved bits, unmapped place
    rchk("control", A_CTL, 32'h0);
    rchk("status", A_ST, 32'h0);
    rd(8'h00);
    `CHK("rd resp", spimsp_pkg::RESP_SLVERR, resp)
    wr(8'h00, 8'hFF);
    `CHK("wr resp", spimsp_pkg::RESP_SLVERR, resp)
    wr(A_ST, 8'hFF);
    rchk("status wr", A_ST, 32'h01);
    wr(A_ST, 8'h00);
    $display("test registers finished");
    // every polarity, phase and bit order, select held low as gpio
    for (int i = 0; i < 8; i++) begin
      mode <= i[2:0];
      ptx  <= 8'h3C + 8'(i * 29);
      wr(A_CTL, {2'b01, i[2], 1'b1, i[1], i[0], 1'b0, i[2]});
      repeat (4) @(posedge clk);
      `CHK("sck idle", i[1], pins_o.sck)
      xfer(8'hA5 ^ 8'(i * 13));
      `CHK("status", 8'h80, rd_q)
      `CHK("peer rx", 8'hA5 ^ 8'(i * 13), prx)
      `CHK("sck stop", i[1], pins_o.sck)
      rchk("data", A_DAT, {24'h0, ptx});
      rchk("data held", A_DAT, {24'h0, ptx});
      rchk("status clr", A_ST, 32'h0);
    end
    $display("test modes finished");
    // every divider code
    mode <= 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(A_ST, {7'h00, c[2]});
      wr(A_CTL, {6'h14, c[1:0]});
      xfer(8'h5A);
      `CHK("sck period", divs[c], per)
      rd(A_DAT);
    end
    wr(A_ST, 8'h00);
    $display("test rates finished");
    // collision, interrupt and its clearing paths
    gie <= 1'b1;
    wr(A_CTL, 8'hD0);
    wr(A_DAT, 8'hE7);
    xfer(8'h18);
    `CHK("status col", 8'hC0, rd_q)
    `CHK("peer rx col", 8'hE7, prx)
    repeat (3) @(posedge clk);
    `CHK("irq on", 1'b1, port_irq)
    rd(A_DAT);
    rchk("status col clr", A_ST, 32'h0);
    `CHK("irq off", 1'b0, port_irq)
    xfer(8'h42);
    vec <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    rchk("status vec", A_ST, 32'h0);
    $display("test flags finished");
    // disabled port does nothing
    wr(A_CTL, 8'h10);
    wr(A_DAT, 8'h77);
    repeat (40) @(posedge clk);
    rchk("status off", A_ST, 32'h0);
    `CHK("sck oe off", 1'b0, pins_oe.sck)
    // select as input: high keeps master, low takes it away
    pin_dir <= 4'hC;
    wr(A_CTL, 8'h50);
    ss_ext <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("ctl loss", A_CTL, 32'h40);
    `CHK("sck oe loss", 1'b0, pins_oe.sck)
    rchk("status loss", A_ST, 32'h80);
    pin_dir <= 4'hE;
    repeat (3) @(posedge clk);
    `CHK("miso oe", 1'b1, pins_oe.miso)
    ss_ext <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("oe passive", 4'h0, pins_oe)
    rchk("ctl slave", A_CTL, 32'h40);
    wr(A_CTL, 8'h50);
    rchk("ctl master", A_CTL, 32'h50);
    $display("test select finished");
    end_of_test();
  end
endmodule
